// ==== caf_can_node.sv ====
`timescale 1ns/1ps
module caf_can_node (
  input wire logic clk,
  input wire logic send,
  input wire logic [28:0] id,
  input wire logic ext,
  output logic RX_VALID,
  output caf_pkg::caf_frame_t RX_FRAME
);
  caf_pkg::caf_frame_t cur;
  caf_pkg::caf_frame_t last_q = '0;
  always_comb begin
    cur.id = id;
    cur.ext = ext;
    cur.data = {3'h0, id, 3'h0, id};
    cur.dlc = 4'h8;
  end
  always_ff @(posedge clk) begin
    if (send) begin
      last_q <= cur;
    end
  end
  // idle bus shows the inverse, so a stale frame can never look valid
  assign RX_VALID = send;
  assign RX_FRAME = send ? cur : ~last_q;
endmodule // caf_can_node

// ==== caf_filter.sv ====
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
// What this block does
// - every bus frame is taken in, then accepted or discarded by filter.
// - full receive address sets exact-match mask and pattern.
// - wildcard digit makes its four identifier bits don't-care.
// - receive address works the same over all 29 extended bits.
// - heavy priority and leading PGN digit are the top 5 identifier bits.
// - heavy format off shows identifier as four raw bytes.
// - receive address is nibble granular; bit level needs pattern and mask.
// - block loads its own defaults suited to the traffic profile; reset loads the 29-bit set whatever the profile.
// - pattern and mask span 11 or 29 bits by frame format.
// - identifier match accepts whole frame, mismatch rejects whole frame.
// - mask one needs equal bits; mask zero ignores that bit.
// - for 11-bit ids, top hex digit gives only 3 bits.
// - the filter applies to every frame, diagnostic replies included.
// - bare receive address, set defaults or warm restart restore defaults.
// - four-byte value uses low 5 bits of first byte only.
// - 11-bit systems use only the 11 low bits of a value.
module caf_filter (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic RX_VALID,
  input wire caf_pkg::caf_frame_t RX_FRAME,
  output logic OUT_VALID,
  output caf_pkg::caf_frame_t OUT_FRAME,
  output logic HEAVY_RAW_FMT
);

  logic rst_s1_q;
  logic rst_n_q;
  caf_pkg::caf_state_t s_q;
  caf_pkg::caf_state_t s_d;

  // reset released through two flops
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // width mask: 11 or 29 bits
  function automatic logic [28:0] width_mask(input logic ext);
    width_mask = ext ? 29'h1FFF_FFFF : 29'h0000_07FF;
  endfunction

  function automatic logic [28:0] def_pattern(input logic [2:0] ctrl);
    if (ctrl[caf_pkg::CTRL_HEAVY_PROFILE]) begin
      def_pattern = caf_pkg::DEF_HVY_PATTERN;
    end else if (ctrl[caf_pkg::CTRL_EXT]) begin
      def_pattern = caf_pkg::DEF_EXT_PATTERN;
    end else begin
      def_pattern = caf_pkg::DEF_STD_PATTERN;
    end
  endfunction

  function automatic logic [28:0] def_mask(input logic [2:0] ctrl);
    if (ctrl[caf_pkg::CTRL_HEAVY_PROFILE]) begin
      def_mask = caf_pkg::DEF_HVY_MASK;
    end else if (ctrl[caf_pkg::CTRL_EXT]) begin
      def_mask = caf_pkg::DEF_EXT_MASK;
    end else begin
      def_mask = caf_pkg::DEF_STD_MASK;
    end
  endfunction

  // nibble wildcards expand to four zero care bits each
  function automatic logic [28:0] wild_mask(input logic [7:0] wild, input logic ext);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      m[i*4 +: 4] = wild[i] ? 4'h0 : 4'hF;
    end
    wild_mask = m[28:0] & width_mask(ext);
  endfunction

  function automatic logic id_match(input logic [28:0] id, input logic [28:0] pat,
                                    input logic [28:0] msk, input logic ext);
    logic [28:0] care;
    care = msk & width_mask(ext);
    id_match = ((id ^ pat) & care) == 29'h0000_0000;
  endfunction

  logic hit;
  assign hit = id_match(RX_FRAME.id & width_mask(RX_FRAME.ext), s_q.pattern, s_q.mask,
                        RX_FRAME.ext);

  always_comb begin
    s_d = s_q;
    s_d.out_valid = 1'b0;
    s_d.rdata = '0;
    // every frame is looked at, decision before output stage
    if (RX_VALID) begin
      if (hit || s_q.show_all) begin
        s_d.out_valid = 1'b1;
        s_d.out_frame = RX_FRAME;
        s_d.acc_cnt = s_q.acc_cnt + 16'h0001;
      end else begin
        s_d.rej_cnt = s_q.rej_cnt + 16'h0001;
      end
    end
    if (WR) begin
      unique case (ADDR)
        caf_pkg::REG_CTRL: begin
          s_d.ctrl = WDATA[2:0];
          // profile change reloads the firmware defaults
          s_d.pattern = def_pattern(WDATA[2:0]);
          s_d.mask = def_mask(WDATA[2:0]);
        end
        // custom pattern bites at once, against whichever mask is already loaded
        caf_pkg::REG_PATTERN: s_d.pattern = WDATA[28:0] & width_mask(s_q.ctrl[0]);
        caf_pkg::REG_MASK: s_d.mask = WDATA[28:0] & width_mask(s_q.ctrl[0]);
        caf_pkg::REG_ADDR_VAL: s_d.addr_val = WDATA;
        caf_pkg::REG_ADDR_WILD: s_d.addr_wild = WDATA[7:0];
        caf_pkg::REG_CMD: begin
          unique case (WDATA[2:0])
            caf_pkg::CMD_RX_ADDR: begin
              // top byte keeps 5 bits, so heavy priority digit lands in id[28:26]
              s_d.mask = wild_mask(s_q.addr_wild, s_q.ctrl[0]);
              s_d.pattern = s_q.addr_val[28:0] & wild_mask(s_q.addr_wild, s_q.ctrl[0]);
              s_d.show_all = 1'b0;
            end
            caf_pkg::CMD_RX_ADDR_DEF, caf_pkg::CMD_SET_DEFAULTS: begin
              s_d.pattern = def_pattern(s_q.ctrl);
              s_d.mask = def_mask(s_q.ctrl);
              s_d.show_all = 1'b0;
            end
            caf_pkg::CMD_WARM_RESTART: begin
              s_d.ctrl = caf_pkg::CTRL_RESET;
              s_d.pattern = def_pattern(caf_pkg::CTRL_RESET);
              s_d.mask = def_mask(caf_pkg::CTRL_RESET);
              s_d.show_all = 1'b0;
              s_d.acc_cnt = '0;
              s_d.rej_cnt = '0;
            end
            caf_pkg::CMD_SHOW_ALL: s_d.show_all = 1'b1;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        caf_pkg::REG_CTRL: s_d.rdata = {29'h0, s_q.ctrl};
        caf_pkg::REG_PATTERN: s_d.rdata = {3'h0, s_q.pattern};
        caf_pkg::REG_MASK: s_d.rdata = {3'h0, s_q.mask};
        caf_pkg::REG_ADDR_VAL: s_d.rdata = s_q.addr_val;
        caf_pkg::REG_ADDR_WILD: s_d.rdata = {24'h0, s_q.addr_wild};
        caf_pkg::REG_STATUS: s_d.rdata = {31'h0, s_q.show_all};
        caf_pkg::REG_ACC_CNT: s_d.rdata = {16'h0, s_q.acc_cnt};
        caf_pkg::REG_REJ_CNT: s_d.rdata = {16'h0, s_q.rej_cnt};
        default: s_d.rdata = '0;
      endcase
    end
    // kept as its own flop so the pin needs no gate after the register
    s_d.raw_fmt = ~s_d.ctrl[caf_pkg::CTRL_HEAVY_FMT];
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= '0;
      s_q.ctrl <= caf_pkg::CTRL_RESET;
      s_q.pattern <= caf_pkg::DEF_EXT_PATTERN;
      s_q.mask <= caf_pkg::DEF_EXT_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  assign OUT_VALID = s_q.out_valid;
  assign OUT_FRAME = s_q.out_frame;
  assign HEAVY_RAW_FMT = s_q.raw_fmt;

  a_reject_blocks: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    RX_VALID && !hit && !s_q.show_all |=> !OUT_VALID)
    else $error("rejected frame reached output");
  a_accept_passes: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    RX_VALID && hit |=> OUT_VALID && OUT_FRAME == $past(RX_FRAME))
    else $error("accepted frame lost");
  a_mask_care: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    OUT_VALID && !s_q.show_all && !$past(s_q.show_all) |->
      ((OUT_FRAME.id ^ $past(s_q.pattern)) & $past(s_q.mask) & width_mask(OUT_FRAME.ext)) == 0)
    else $error("output frame breaks mask");
  a_addr_exact: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    WR && ADDR == caf_pkg::REG_CMD && WDATA[2:0] == caf_pkg::CMD_RX_ADDR
      && s_q.addr_wild == 8'h00 && s_q.ctrl[0] |=> s_q.mask == 29'h1FFF_FFFF)
    else $error("exact address not full mask");
  a_wild_nibble: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    WR && ADDR == caf_pkg::REG_CMD && WDATA[2:0] == caf_pkg::CMD_RX_ADDR
      && s_q.addr_wild[0] |=> s_q.mask[3:0] == 4'h0)
    else $error("wildcard nibble still cared");
  a_std_width: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    WR && ADDR == caf_pkg::REG_MASK && !s_q.ctrl[0] |=> s_q.mask[28:11] == 0)
    else $error("11-bit mask has high bits");
  a_defaults_back: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    WR && ADDR == caf_pkg::REG_CMD && WDATA[2:0] == caf_pkg::CMD_SET_DEFAULTS
      |=> s_q.mask == def_mask(s_q.ctrl) && s_q.pattern == def_pattern(s_q.ctrl))
    else $error("defaults not restored");
  a_read_data: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    RD && ADDR == caf_pkg::REG_MASK && !WR |=> RDATA == {3'h0, $past(s_q.mask)})
    else $error("mask readback wrong");
  a_count_rej: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    RX_VALID && !hit && !s_q.show_all && !WR |=> s_q.rej_cnt == $past(s_q.rej_cnt) + 16'h0001)
    else $error("reject not counted");
  a_warm_clear: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    WR && ADDR == caf_pkg::REG_CMD && WDATA[2:0] == caf_pkg::CMD_WARM_RESTART
      |=> s_q.acc_cnt == 16'h0000 && s_q.rej_cnt == 16'h0000 && s_q.ctrl == caf_pkg::CTRL_RESET)
    else $error("warm restart left state");
  a_show_pass: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    RX_VALID && s_q.show_all |=> OUT_VALID)
    else $error("show all dropped frame");
  a_ctrl_reload: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    WR && ADDR == caf_pkg::REG_CTRL
      |=> s_q.mask == def_mask(s_q.ctrl) && s_q.pattern == def_pattern(s_q.ctrl))
    else $error("profile defaults not loaded");
  a_std_exact: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    WR && ADDR == caf_pkg::REG_CMD && WDATA[2:0] == caf_pkg::CMD_RX_ADDR
      && s_q.addr_wild == 8'h00 && !s_q.ctrl[0] |=> s_q.mask == 29'h0000_07FF)
    else $error("11-bit exact mask wrong");
  a_addr_pattern: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    WR && ADDR == caf_pkg::REG_CMD && WDATA[2:0] == caf_pkg::CMD_RX_ADDR
      |=> s_q.pattern == ($past(s_q.addr_val[28:0]) & s_q.mask))
    else $error("address pattern wrong");
  a_raw_fmt: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    HEAVY_RAW_FMT == !s_q.ctrl[caf_pkg::CTRL_HEAVY_FMT])
    else $error("raw format pin wrong");
  a_rdata_idle: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    !RD |=> RDATA == 32'h0000_0000)
    else $error("read data without read");

  c_accept: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q) RX_VALID && hit);
  c_reject: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q) RX_VALID && !hit);
  c_wild: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    WR && ADDR == caf_pkg::REG_CMD && WDATA[2:0] == caf_pkg::CMD_RX_ADDR && s_q.addr_wild != 0);
  c_warm: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
    WR && ADDR == caf_pkg::REG_CMD && WDATA[2:0] == caf_pkg::CMD_WARM_RESTART);

endmodule // caf_filter

// ==== caf_pkg.sv ====
package caf_pkg;

  localparam int ID_W = 29;
  localparam int STD_W = 11;

  // register word indices on the plain port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PATTERN = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_ADDR_VAL = 4'h3;
  localparam logic [3:0] REG_ADDR_WILD = 4'h4;
  localparam logic [3:0] REG_CMD = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_ACC_CNT = 4'h7;
  localparam logic [3:0] REG_REJ_CNT = 4'h8;

  // command codes written to REG_CMD
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_RX_ADDR = 3'h1;
  localparam logic [2:0] CMD_RX_ADDR_DEF = 3'h2;
  localparam logic [2:0] CMD_SET_DEFAULTS = 3'h3;
  localparam logic [2:0] CMD_WARM_RESTART = 3'h4;
  localparam logic [2:0] CMD_SHOW_ALL = 3'h5;

  // ctrl bits
  localparam int CTRL_EXT = 0;
  localparam int CTRL_HEAVY_FMT = 1;
  localparam int CTRL_HEAVY_PROFILE = 2;

  // default acceptance for each traffic profile (diagnostic replies; heavy profile accepts all)
  localparam logic [28:0] DEF_STD_PATTERN = 29'h0000_07E8;
  localparam logic [28:0] DEF_STD_MASK = 29'h0000_07F8;
  localparam logic [28:0] DEF_EXT_PATTERN = 29'h18DA_F100;
  localparam logic [28:0] DEF_EXT_MASK = 29'h1FFF_FF00;
  localparam logic [28:0] DEF_HVY_PATTERN = 29'h0000_0000;
  localparam logic [28:0] DEF_HVY_MASK = 29'h0000_0000;
  localparam logic [2:0] CTRL_RESET = 3'h2;

  typedef struct packed {
    logic [28:0] id;
    logic ext;
    logic [63:0] data;
    logic [3:0] dlc;
  } caf_frame_t;

  typedef struct packed {
    logic [2:0] ctrl;
    logic [28:0] pattern;
    logic [28:0] mask;
    logic [31:0] addr_val;
    logic [7:0] addr_wild;
    logic show_all;
    logic [15:0] acc_cnt;
    logic [15:0] rej_cnt;
    logic out_valid;
    caf_frame_t out_frame;
    logic [31:0] rdata;
    logic raw_fmt;
  } caf_state_t;

endpackage

// ==== tb_can_rx_acceptance_filter.sv ====
`timescale 1ns/1ps
module tb_can_rx_acceptance_filter;
  typedef struct packed {
    logic receive_address_command;
    logic [2:0] ctrl;
    logic [31:0] val;
    logic [31:0] aux;
    logic [28:0] id;
    logic ext;
    logic acc;
  } caf_row_t;
  localparam caf_row_t ROWS [14] = '{
    '{1'b0, 3'h0, 32'h0000_07E8, 32'h0000_07F8, 29'h0000_07EF, 1'b0, 1'b1},
    '{1'b0, 3'h0, 32'h0000_07E8, 32'h0000_07F8, 29'h0000_07E7, 1'b0, 1'b0},
    '{1'b0, 3'h0, 32'h0000_07E8, 32'h0000_07F8, 29'h1555_07E8, 1'b0, 1'b1},
    '{1'b0, 3'h0, 32'hFFFF_F7E9, 32'hFFFF_FFFF, 29'h0000_07E9, 1'b0, 1'b1},
    '{1'b0, 3'h0, 32'hFFFF_F7E9, 32'hFFFF_FFFF, 29'h0000_07E8, 1'b0, 1'b0},
    '{1'b1, 3'h0, 32'h0000_07E9, 32'h0000_0000, 29'h0000_07E9, 1'b0, 1'b1},
    '{1'b1, 3'h0, 32'h0000_07E9, 32'h0000_0000, 29'h0000_07E8, 1'b0, 1'b0},
    '{1'b1, 3'h0, 32'h0000_07E0, 32'h0000_0001, 29'h0000_07E5, 1'b0, 1'b1},
    '{1'b1, 3'h0, 32'h0000_07E0, 32'h0000_0001, 29'h0000_07D5, 1'b0, 1'b0},
    '{1'b1, 3'h1, 32'h18DA_F100, 32'h0000_0003, 29'h18DA_F155, 1'b1, 1'b1},
    '{1'b1, 3'h1, 32'h18DA_F100, 32'h0000_0003, 29'h18DA_F255, 1'b1, 1'b0},
    '{1'b0, 3'h1, 32'hF8DA_F100, 32'h1FFF_FF00, 29'h18DA_F110, 1'b1, 1'b1},
    '{1'b1, 3'h1, 32'h18FE_F500, 32'h0000_0003, 29'h18FE_F5AA, 1'b1, 1'b1},
    '{1'b1, 3'h1, 32'h18FE_F500, 32'h0000_0003, 29'h0CFE_F500, 1'b1, 1'b0}};
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0000_0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic RX_VALID;
  caf_pkg::caf_frame_t RX_FRAME;
  logic OUT_VALID;
  caf_pkg::caf_frame_t OUT_FRAME;
  logic HEAVY_RAW_FMT;
  logic send = 1'b0;
  logic [28:0] fid = 29'h0000_0000;
  logic fext = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  logic [31:0] rv;
  initial begin
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  caf_can_node i_node (.clk(SYS_CLK), .send(send), .id(fid), .ext(fext),
    .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME));
  caf_filter i_dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME),
    .OUT_VALID(OUT_VALID), .OUT_FRAME(OUT_FRAME), .HEAVY_RAW_FMT(HEAVY_RAW_FMT));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask
  // one frame, then look at the single-cycle answer
  task automatic sendf(input logic [28:0] id, input logic ext, input logic acc);
    @(posedge SYS_CLK);
    send <= 1'b1;
    fid <= id;
    fext <= ext;
    @(posedge SYS_CLK);
    send <= 1'b0;
    #1 chk("out_valid", {31'h0, OUT_VALID}, {31'h0, acc});
    if (acc) chk("out_id", {3'h0, OUT_FRAME.id}, {3'h0, id});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    chk("raw_fmt", {31'h0, HEAVY_RAW_FMT}, 32'h0000_0000);
    rd(caf_pkg::REG_CTRL);
    chk("ctrl", rv, 32'h0000_0002);
    rd(caf_pkg::REG_PATTERN);
    chk("pattern", rv, 32'h18DA_F100);
    rd(caf_pkg::REG_MASK);
    chk("mask", rv, 32'h1FFF_FF00);
    rd(4'hF);
    chk("unmapped", rv, 32'h0000_0000);
    $display("test reset done");
    foreach (ROWS[i]) begin
      wr(caf_pkg::REG_CTRL, {29'h0, ROWS[i].ctrl});
      if (ROWS[i].receive_address_command) begin
        wr(caf_pkg::REG_ADDR_VAL, ROWS[i].val);
        wr(caf_pkg::REG_ADDR_WILD, ROWS[i].aux);
        wr(caf_pkg::REG_CMD, {29'h0, caf_pkg::CMD_RX_ADDR});
      end else begin
        wr(caf_pkg::REG_PATTERN, ROWS[i].val);
        wr(caf_pkg::REG_MASK, ROWS[i].aux);
      end
      sendf(ROWS[i].id, ROWS[i].ext, ROWS[i].acc);
    end
    $display("test table done");
    wr(caf_pkg::REG_CTRL, 32'h0000_0000);
    #1 chk("raw_fmt", {31'h0, HEAVY_RAW_FMT}, 32'h0000_0001);
    @(posedge SYS_CLK);
    send <= 1'b1;
    fext <= 1'b0;
    fid <= 29'h0000_07E8;
    @(posedge SYS_CLK);
    fid <= 29'h0000_07E9;
    #1 chk("b2b_first", {31'h0, OUT_VALID}, 32'h0000_0001);
    @(posedge SYS_CLK);
    fid <= 29'h0000_0123;
    #1 chk("b2b_second", {3'h0, OUT_FRAME.id}, 32'h0000_07E9);
    @(posedge SYS_CLK);
    send <= 1'b0;
    #1 chk("b2b_third", {31'h0, OUT_VALID}, 32'h0000_0000);
    $display("test back to back done");
    for (int c = 2; c <= 3; c++) begin
      wr(caf_pkg::REG_PATTERN, 32'h0000_0123);
      wr(caf_pkg::REG_MASK, 32'h0000_07FF);
      wr(caf_pkg::REG_CMD, c);
      rd(caf_pkg::REG_MASK);
      chk("def_mask", rv, 32'h0000_07F8);
      rd(caf_pkg::REG_PATTERN);
      chk("def_pattern", rv, 32'h0000_07E8);
    end
    wr(caf_pkg::REG_CMD, {29'h0, caf_pkg::CMD_WARM_RESTART});
    rd(caf_pkg::REG_ACC_CNT);
    chk("acc_cnt", rv, 32'h0000_0000);
    rd(caf_pkg::REG_REJ_CNT);
    chk("rej_cnt", rv, 32'h0000_0000);
    rd(caf_pkg::REG_PATTERN);
    chk("warm_pattern", rv, 32'h0000_07E8);
    $display("test defaults done");
    wr(caf_pkg::REG_CTRL, 32'h0000_0000);
    wr(caf_pkg::REG_CMD, {29'h0, caf_pkg::CMD_SHOW_ALL});
    rd(caf_pkg::REG_STATUS);
    chk("show_all", rv, 32'h0000_0001);
    sendf(29'h0000_0123, 1'b0, 1'b1);
    $display("test show all done");
    conclude();
  end
endmodule // tb_can_rx_acceptance_filter
